/* File: core/acrb_defines.svh */
// Purpose: offsets, fields, reset values of the converter config bank
// Assumes: 8-bit address and data after serial deserialising
// Notes: offsets, reset values, field positions, toggle words and gain limit live here as macros
// Behaviour
// - format bit selects twos complement or offset
// - slow rate bit selects low speed
// - sleep bit powers down core and buffers
// - pattern field picks output content
// - code 011 drives alternating toggle pattern
// - code 100 drives incrementing 16-bit ramp
// - code 101 drives the user word
// - low user register gives bits 7:0
// - high user register gives bits 15:8
// - port select 00 follows strap pin
// - port select 01 forces DDR LVDS
// - port select 11 forces parallel CMOS
// - reference bit selects internal or external
// - soft reset bit restores all defaults
`ifndef ACRB_DEFINES_SVH
`define ACRB_DEFINES_SVH
`define ACRB_OFS_MODE    8'h63
`define ACRB_OFS_PATT    8'h65
`define ACRB_OFS_GAIN    8'h68
`define ACRB_OFS_USER_LO 8'h69
`define ACRB_OFS_USER_HI 8'h6A
`define ACRB_OFS_PORT    8'h6C
`define ACRB_OFS_VREF    8'h6D
`define ACRB_OFS_SOFT    8'h6E
`define ACRB_OFS_DRIVE   8'h7E
`define ACRB_RST_MODE    8'h00
`define ACRB_RST_PATT    8'h00
`define ACRB_RST_GAIN    8'h09
`define ACRB_RST_USER    8'h00
`define ACRB_RST_PORT    8'h00
`define ACRB_RST_VREF    8'h00
`define ACRB_RST_DRIVE   8'h00
`define ACRB_BIT_SLOW    0
`define ACRB_BIT_FMT     3
`define ACRB_BIT_SLEEP   7
`define ACRB_BIT_VREF    4
`define ACRB_BIT_SOFT    0
`define ACRB_PATT_HI     7
`define ACRB_PATT_LO     5
`define ACRB_PORT_HI     4
`define ACRB_PORT_LO     3
`define ACRB_GAIN_HI     3
`define ACRB_DRIVE_HI    1
`define ACRB_TOGGLE_A    16'hAAAA
`define ACRB_TOGGLE_B    16'h5555
`define ACRB_GAIN_LIMIT  3'h6
`endif

/* File: core/acrb_pkg.sv */
// Purpose: types of the converter config bank
// Assumes: none
// Notes: codes match the field encodings
package acrb_pkg;
  typedef enum logic [2:0] {
    ACRB_PAT_NORMAL = 3'h0,
    ACRB_PAT_ZEROS  = 3'h1,
    ACRB_PAT_ONES   = 3'h2,
    ACRB_PAT_TOGGLE = 3'h3,
    ACRB_PAT_RAMP   = 3'h4,
    ACRB_PAT_USER   = 3'h5,
    ACRB_PAT_RSVD   = 3'h6,
    ACRB_PAT_UNUSED = 3'h7
  } acrb_pat_t;

  typedef enum logic [1:0] {
    ACRB_PORT_STRAP = 2'h0,
    ACRB_PORT_LVDS  = 2'h1,
    ACRB_PORT_ALT   = 2'h2,
    ACRB_PORT_CMOS  = 2'h3
  } acrb_port_t;

  typedef struct packed {
    logic       sleep;
    logic       low_speed;
    logic       offset_binary;
    logic       ext_ref;
    logic       lvds_mode;
    logic [2:0] gain_db;
    logic [1:0] drive_code;
  } acrb_cfg_t;
endpackage

/* File: core/acrb_top.sv */
// Purpose: register bank steering converter core and output formatter
// Assumes: serial frames already decoded into byte writes and reads
// Notes: strap high selects LVDS, low selects CMOS
`timescale 1ns/100ps
`include "acrb_defines.svh"

module acrb_top #(
  parameter int DW = 16
) (
  input  wire logic               clk,        // 25 MHz clock
  input  wire logic               rst,        // async reset, high
  input  wire logic               wr_en,      // byte write strobe
  input  wire logic [7:0]         wr_addr,    // write address
  input  wire logic [7:0]         wr_data,    // write data
  input  wire logic               rd_en,      // read strobe
  input  wire logic [7:0]         rd_addr,    // read address
  output logic      [7:0]         rd_data,    // read data, next cycle
  input  wire logic               format_strap_pin, // interface strap
  input  wire logic [DW-1:0]      sample_in,  // twos complement sample
  output logic [DW-1:0]           data_out,   // formatted output word
  output acrb_pkg::acrb_cfg_t     cfg         // decoded settings
);

  // formatter and patterns are written for one word width only
  if (DW != 16) begin : g_bad_width
    $error("acrb_top supports only 16-bit words");
  end

  logic [7:0] mode_reg;
  logic [7:0] patt_reg;
  logic [7:0] gain_reg;
  logic [7:0] user_lo;
  logic [7:0] user_hi;
  logic [7:0] port_reg;
  logic [7:0] vref_reg;
  logic [7:0] drive_reg;
  logic [DW-1:0] ramp;
  logic          toggle_ph;

  // write decode
  wire soft_clr = wr_en && (wr_addr == `ACRB_OFS_SOFT)
                  && wr_data[`ACRB_BIT_SOFT];
  wire wr_mode  = wr_en && (wr_addr == `ACRB_OFS_MODE);
  wire wr_patt  = wr_en && (wr_addr == `ACRB_OFS_PATT);
  wire wr_gain  = wr_en && (wr_addr == `ACRB_OFS_GAIN);
  wire wr_ulo   = wr_en && (wr_addr == `ACRB_OFS_USER_LO);
  wire wr_uhi   = wr_en && (wr_addr == `ACRB_OFS_USER_HI);
  wire wr_port  = wr_en && (wr_addr == `ACRB_OFS_PORT);
  wire wr_vref  = wr_en && (wr_addr == `ACRB_OFS_VREF);
  wire wr_drive = wr_en && (wr_addr == `ACRB_OFS_DRIVE);

  // soft reset wins over any other write; the clear byte itself reads 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg  <= `ACRB_RST_MODE;
      patt_reg  <= `ACRB_RST_PATT;
      gain_reg  <= `ACRB_RST_GAIN;
      user_lo   <= `ACRB_RST_USER;
      user_hi   <= `ACRB_RST_USER;
      port_reg  <= `ACRB_RST_PORT;
      vref_reg  <= `ACRB_RST_VREF;
      drive_reg <= `ACRB_RST_DRIVE;
    end else if (soft_clr) begin
      mode_reg  <= `ACRB_RST_MODE;
      patt_reg  <= `ACRB_RST_PATT;
      gain_reg  <= `ACRB_RST_GAIN;
      user_lo   <= `ACRB_RST_USER;
      user_hi   <= `ACRB_RST_USER;
      port_reg  <= `ACRB_RST_PORT;
      vref_reg  <= `ACRB_RST_VREF;
      drive_reg <= `ACRB_RST_DRIVE;
    end else begin
      // unused bits are stored as written; host keeps them zero except in the user and drive registers
      if (wr_mode)  mode_reg  <= wr_data;
      if (wr_patt)  patt_reg  <= wr_data;
      if (wr_gain)  gain_reg  <= wr_data;
      if (wr_ulo)   user_lo   <= wr_data;
      if (wr_uhi)   user_hi   <= wr_data;
      if (wr_port)  port_reg  <= wr_data;
      if (wr_vref)  vref_reg  <= wr_data;
      if (wr_drive) drive_reg <= wr_data;
    end
  end

  // read decode
  logic [7:0] rd_mux;
  assign rd_mux =
    (rd_addr == `ACRB_OFS_MODE)    ? mode_reg  :
    (rd_addr == `ACRB_OFS_PATT)    ? patt_reg  :
    (rd_addr == `ACRB_OFS_GAIN)    ? gain_reg  :
    (rd_addr == `ACRB_OFS_USER_LO) ? user_lo   :
    (rd_addr == `ACRB_OFS_USER_HI) ? user_hi   :
    (rd_addr == `ACRB_OFS_PORT)    ? port_reg  :
    (rd_addr == `ACRB_OFS_VREF)    ? vref_reg  :
    (rd_addr == `ACRB_OFS_DRIVE)   ? drive_reg : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= rd_mux;
    end
  end

  // field decode
  wire acrb_pkg::acrb_pat_t pat_sel =
    acrb_pkg::acrb_pat_t'(patt_reg[`ACRB_PATT_HI:`ACRB_PATT_LO]);
  wire acrb_pkg::acrb_port_t port_sel =
    acrb_pkg::acrb_port_t'(port_reg[`ACRB_PORT_HI:`ACRB_PORT_LO]);
  wire [3:0] gain_code = gain_reg[`ACRB_GAIN_HI:0];
  wire [15:0] user_word = {user_hi, user_lo};

  // code 10 is undefined, treated as strap
  wire next_lvds = (port_sel == acrb_pkg::ACRB_PORT_LVDS) ? 1'b1 :
                   (port_sel == acrb_pkg::ACRB_PORT_CMOS) ? 1'b0 :
                   format_strap_pin;

  // code 1111 saturates at the top step set by code 1110
  wire [2:0] next_gain =
    !gain_code[3]                     ? 3'h1 :
    (gain_code[2:0] > `ACRB_GAIN_LIMIT) ? `ACRB_GAIN_LIMIT :
    gain_code[2:0];

  acrb_pkg::acrb_cfg_t next_cfg;
  always_comb begin
    next_cfg.sleep         = mode_reg[`ACRB_BIT_SLEEP];
    next_cfg.low_speed     = mode_reg[`ACRB_BIT_SLOW];
    next_cfg.offset_binary = mode_reg[`ACRB_BIT_FMT];
    next_cfg.ext_ref       = vref_reg[`ACRB_BIT_VREF];
    next_cfg.lvds_mode     = next_lvds;
    next_cfg.gain_db       = next_gain;
    next_cfg.drive_code    = drive_reg[`ACRB_DRIVE_HI:0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // pattern generators run freely so a switch lands mid-sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp      <= '0;
      toggle_ph <= 1'b0;
    end else begin
      ramp      <= ramp + 16'h0001;
      toggle_ph <= ~toggle_ph;
    end
  end

  // offset binary is the twos complement word with sign bit flipped
  wire [DW-1:0] coded = mode_reg[`ACRB_BIT_FMT] ?
    {~sample_in[DW-1], sample_in[DW-2:0]} : sample_in;

  logic [DW-1:0] next_data;
  always_comb begin
    case (pat_sel)
      acrb_pkg::ACRB_PAT_NORMAL: next_data = coded;
      acrb_pkg::ACRB_PAT_ZEROS:  next_data = 16'h0000;
      acrb_pkg::ACRB_PAT_ONES:   next_data = 16'hFFFF;
      acrb_pkg::ACRB_PAT_TOGGLE: next_data = toggle_ph ?
                                   `ACRB_TOGGLE_B : `ACRB_TOGGLE_A;
      acrb_pkg::ACRB_PAT_RAMP:   next_data = ramp;
      acrb_pkg::ACRB_PAT_USER:   next_data = user_word;
      default:                   next_data = 16'h0000;
    endcase
    if (mode_reg[`ACRB_BIT_SLEEP]) begin
      next_data = 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
    end else begin
      data_out <= next_data;
    end
  end

  // checks
  a_soft_clear: assert property (@(posedge clk) disable iff (rst)
    soft_clr |=> (mode_reg == `ACRB_RST_MODE) && (gain_reg == `ACRB_RST_GAIN)
      && (patt_reg == `ACRB_RST_PATT) && (port_reg == `ACRB_RST_PORT)
      && (user_lo == `ACRB_RST_USER) && (user_hi == `ACRB_RST_USER)
      && (vref_reg == `ACRB_RST_VREF) && (drive_reg == `ACRB_RST_DRIVE))
    else $error("soft reset left a register changed");

  a_ramp_step: assert property (@(posedge clk) disable iff (rst)
    (pat_sel == acrb_pkg::ACRB_PAT_RAMP && !mode_reg[`ACRB_BIT_SLEEP])
      ##1 (pat_sel == acrb_pkg::ACRB_PAT_RAMP && !mode_reg[`ACRB_BIT_SLEEP])
      |=> data_out == $past(data_out) + 16'h0001)
    else $error("ramp did not advance by one");

  // the word before the switch came from the old pattern, so skip it
  a_toggle_alt: assert property (@(posedge clk) disable iff (rst)
    (pat_sel == acrb_pkg::ACRB_PAT_TOGGLE && !mode_reg[`ACRB_BIT_SLEEP])
      |=> (data_out == `ACRB_TOGGLE_A || data_out == `ACRB_TOGGLE_B)
        && (data_out != $past(data_out) || $past(pat_sel, 2)
           != acrb_pkg::ACRB_PAT_TOGGLE))
    else $error("toggle pattern wrong");

  a_user_word: assert property (@(posedge clk) disable iff (rst)
    (pat_sel == acrb_pkg::ACRB_PAT_USER && !mode_reg[`ACRB_BIT_SLEEP])
      |=> data_out == {$past(user_hi), $past(user_lo)})
    else $error("user word not output");

  a_user_lo_wr: assert property (@(posedge clk) disable iff (rst)
    wr_ulo && !soft_clr |=> user_lo == $past(wr_data))
    else $error("low user byte not stored");

  a_user_hi_wr: assert property (@(posedge clk) disable iff (rst)
    wr_uhi && !soft_clr |=> user_hi == $past(wr_data))
    else $error("high user byte not stored");

  a_fixed_patt: assert property (@(posedge clk) disable iff (rst)
    (pat_sel == acrb_pkg::ACRB_PAT_ONES && !mode_reg[`ACRB_BIT_SLEEP])
      |=> data_out == 16'hFFFF)
    else $error("all ones pattern wrong");

  a_normal_fmt: assert property (@(posedge clk) disable iff (rst)
    (pat_sel == acrb_pkg::ACRB_PAT_NORMAL && !mode_reg[`ACRB_BIT_SLEEP])
      |=> data_out[DW-1] == ($past(sample_in[DW-1]) ^ $past(mode_reg[3])))
    else $error("number format wrong");

  a_sleep_out: assert property (@(posedge clk) disable iff (rst)
    mode_reg[`ACRB_BIT_SLEEP] |=> cfg.sleep && data_out == 16'h0000)
    else $error("sleep did not quiet outputs");

  a_strap_port: assert property (@(posedge clk) disable iff (rst)
    port_sel == acrb_pkg::ACRB_PORT_STRAP
      |=> cfg.lvds_mode == $past(format_strap_pin))
    else $error("strap not followed");

  a_forced_port: assert property (@(posedge clk) disable iff (rst)
    (port_sel == acrb_pkg::ACRB_PORT_LVDS |=> cfg.lvds_mode) and
    (port_sel == acrb_pkg::ACRB_PORT_CMOS |=> !cfg.lvds_mode))
    else $error("forced interface ignored");

  a_gain_map: assert property (@(posedge clk) disable iff (rst)
    !gain_code[3] |=> cfg.gain_db == 3'h1)
    else $error("gain default step wrong");

  a_slow_ref: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> cfg.low_speed == $past(mode_reg[0])
      && cfg.ext_ref == $past(vref_reg[4])
      && cfg.drive_code == $past(drive_reg[1:0]))
    else $error("mode bits not carried");

endmodule

/* File: tb/acrb_host.sv */
// Purpose: host model that programs the config bank one byte at a time
// Assumes: strobes change on the falling edge, one idle cycle between requests
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/100ps
module acrb_host (
  input  wire logic       clk,     // bank clock
  output logic            wr_en,   // write strobe
  output logic      [7:0] wr_addr, // write address
  output logic      [7:0] wr_data, // write byte
  output logic            rd_en,   // read strobe
  output logic      [7:0] rd_addr, // read address
  input  wire logic [7:0] rd_data  // read byte
);
  function automatic logic [7:0] used_bits(input logic [7:0] a);
    case (a)
      8'h63: used_bits = 8'h89;
      8'h65: used_bits = 8'hE0;
      8'h68: used_bits = 8'h0F;
      8'h6C: used_bits = 8'h18;
      8'h6D: used_bits = 8'h10;
      8'h6E: used_bits = 8'h01;
      default: used_bits = 8'hFF;
    endcase
  endfunction
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d & used_bits(a);
    @(negedge clk);
    wr_en   = 1'b0;
    wr_addr = ~wr_addr;
    wr_data = ~wr_data;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clk);
    d       = rd_data;
    rd_en   = 1'b0;
    rd_addr = ~rd_addr;
  endtask
endmodule

/* File: tb/adc_config_register_bank_test.sv */
// Purpose: self-checking bench for the converter config bank
// Assumes: inputs change on the falling edge
// Notes: ramp is checked by step only, its free-running phase is not tracked
`timescale 1ns/100ps
module adc_config_register_bank_test;
  logic                clk;
  logic                rst;
  logic                strap;
  logic [15:0]         smp;
  logic                wr_en;
  logic                rd_en;
  logic [7:0]          wr_addr;
  logic [7:0]          wr_data;
  logic [7:0]          rd_addr;
  logic [7:0]          rd_data;
  logic [7:0]          rv;
  logic [15:0]         data_out;
  logic [15:0]         w;
  acrb_pkg::acrb_cfg_t cfg;
  int                  err_count;
  int                  checks;
  int                  cyc;
  logic [7:0] ofs [10] = '{8'h63, 8'h65, 8'h68, 8'h69, 8'h6A, 8'h6C, 8'h6D, 8'h6E, 8'h7E, 8'h64};
  logic [7:0] gc [4] = '{8'h00, 8'h08, 8'h0D, 8'h0E};
  logic [7:0] gd [4] = '{8'h01, 8'h00, 8'h05, 8'h06};
  logic [7:0] pc [3] = '{8'h20, 8'h40, 8'hE0};
  logic [15:0] pd [3] = '{16'h0000, 16'hFFFF, 16'h0000};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  acrb_host host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
  acrb_top #(.DW(16)) dut (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .format_strap_pin(strap), .sample_in(smp), .data_out(data_out), .cfg(cfg));

  task automatic wrap_up;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // write, then let register and output stages land
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    repeat (2) @(negedge clk);
  endtask
  task automatic defaults;
    for (int i = 0; i < 10; i++) begin
      host.rd(ofs[i], rv);
      chk8("register", (ofs[i] == 8'h68) ? 8'h09 : 8'h00, rv);
    end
  endtask

  // hang guard: the full sequence needs about 150 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    rst   = 1'b1;
    strap = 1'b1;
    smp   = 16'h1234;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk8("lvds_mode", 8'h01, 8'(cfg.lvds_mode));
    chk8("gain_db", 8'h01, 8'(cfg.gain_db));
    defaults();
    put(8'h63, 8'h89);
    chk8("sleep", 8'h01, 8'(cfg.sleep));
    chk8("low_speed", 8'h01, 8'(cfg.low_speed));
    chk8("offset_binary", 8'h01, 8'(cfg.offset_binary));
    chk16("data_out", 16'h0000, data_out);
    put(8'h63, 8'h08);
    chk16("data_out", 16'h9234, data_out);
    smp = 16'hF234;
    @(negedge clk);
    chk16("data_out", 16'h7234, data_out);
    smp = 16'h1234;
    put(8'h63, 8'h00);
    chk16("data_out", 16'h1234, data_out);
    for (int i = 0; i < 3; i++) begin
      put(8'h65, pc[i]);
      chk16("pattern", pd[i], data_out);
    end
    put(8'h65, 8'h60);
    w = data_out;
    chk8("toggle", 8'h01, 8'(w == 16'hAAAA || w == 16'h5555));
    @(negedge clk);
    chk16("toggle", ~w, data_out);
    put(8'h65, 8'h80);
    for (int i = 0; i < 3; i++) begin
      w = data_out;
      @(negedge clk);
      chk16("ramp", w + 16'h0001, data_out);
    end
    put(8'h69, 8'h3C);
    put(8'h6A, 8'hC3);
    put(8'h65, 8'hA0);
    chk16("user word", 16'hC33C, data_out);
    strap = 1'b0;
    put(8'h6C, 8'h00);
    chk8("lvds_mode", 8'h00, 8'(cfg.lvds_mode));
    put(8'h6C, 8'h08);
    chk8("lvds_mode", 8'h01, 8'(cfg.lvds_mode));
    strap = 1'b1;
    put(8'h6C, 8'h18);
    chk8("lvds_mode", 8'h00, 8'(cfg.lvds_mode));
    put(8'h6C, 8'h10);
    chk8("lvds_mode", 8'h01, 8'(cfg.lvds_mode));
    put(8'h6D, 8'h10);
    chk8("ext_ref", 8'h01, 8'(cfg.ext_ref));
    for (int i = 0; i < 4; i++) begin
      put(8'h68, gc[i]);
      chk8("gain_db", gd[i], 8'(cfg.gain_db));
    end
    for (int i = 0; i < 4; i++) begin
      put(8'h7E, 8'(i));
      chk8("drive_code", 8'(i), 8'(cfg.drive_code));
    end
    put(8'h6E, 8'h01);
    defaults();
    chk16("data_out", 16'h1234, data_out);
    chk8("lvds_mode", 8'h01, 8'(cfg.lvds_mode));
    wrap_up();
  end
endmodule
